// *** utp_params.svh ***
/*
 * offsets, field positions, reset values and divider masks of the
 * universal timer block. assumes a 4-bit word address on the register
 * port and a 16-bit data path.
 */
`ifndef UTP_PARAMS_SVH
`define UTP_PARAMS_SVH

// register word addresses
`define UTP_A_PRELOAD   4'h0
`define UTP_A_COUNT     4'h1
`define UTP_A_SELECT    4'h2
`define UTP_B_PRELOAD   4'h3
`define UTP_B_COUNT     4'h4
`define UTP_B_SELECT    4'h5
`define UTP_C_PRELOAD   4'h6
`define UTP_C_COUNT     4'h7
`define UTP_C_SELECT    4'h8
`define UTP_PWM_CTRL    4'h9
`define UTP_INT_STATUS  4'hA
`define UTP_INT_CLEAR   4'hB
`define UTP_INT_ENABLE  4'hC
`define UTP_ROUTE       4'hD
`define UTP_STROBE_SEL  4'hE
`define UTP_PIN_LEVEL   4'hF

// reset values
`define UTP_RST_WORD    16'h0000
`define UTP_RST_SEL     4'h0
`define UTP_RST_PWM     8'h00

// pwm duty limits
`define UTP_PWM_MIN     8'h01
`define UTP_PWM_MAX     8'hFE

// timebase tick masks on the 14-bit rtc edge divider
`define UTP_M_4K        14'h0007
`define UTP_M_2K        14'h000F
`define UTP_M_512       14'h003F
`define UTP_M_64        14'h01FF
`define UTP_M_16        14'h07FF
`define UTP_M_2         14'h3FFF

// square-wave taps for the timer second input
`define UTP_TAP_64      8
`define UTP_TAP_16      10
`define UTP_TAP_2       13

// status bit positions
`define UTP_ST_TMR      0
`define UTP_ST_TB       3
`define UTP_ST_W        9

`define UTP_CNT_MAX     16'hFFFF

`endif

// *** utp_pkg.sv ***
/*
 * types of the universal timer block.
 * assumes utp_params.svh is compiled alongside.
 */
package utp_pkg;

  typedef enum logic [1:0] {
    UTP_STB_NONE = 2'b00,
    UTP_STB_A    = 2'b01,
    UTP_STB_B    = 2'b10,
    UTP_STB_C    = 2'b11
  } utp_strobe_t;

  typedef struct packed {
    logic [3:0]        sync1_ff;
    logic [3:0]        sync2_ff;
    logic              rtc_prev_ff;
    logic [13:0]       tb_cnt_ff;
    logic [2:0]        lvl_prev_ff;
    logic [2:0][15:0]  pre_ff;
    logic [2:0][15:0]  cnt_ff;
    logic [2:0][3:0]   sel_ff;
    logic [2:0][3:0]   sel_act_ff;
    logic [7:0]        pwm_w_ff;
    logic [7:0]        pwm_cnt_ff;
    logic              pwm_q_ff;
    logic [8:0]        stat_ff;
    logic [8:0]        en_ff;
    logic [1:0]        route_ff;
    utp_strobe_t       dac_sel_ff;
    utp_strobe_t       adc_sel_ff;
    logic [15:0]       rdata_ff;
    logic [2:0]        ovf_ff;
    logic              dac_ff;
    logic              adc_ff;
    logic [1:0]        tbn_ff;
    logic [1:0]        tbf_ff;
    logic              wake_ff;
    logic              irq_ff;
  } utp_state_t;

endpackage

// *** utp_timer.sv ***
/*
 * universal timer block: three reload timers, pwm output, timebase
 * divider, interrupt status and strobe routing, one register port.
 * assumes one 10 MHz clock; rtc, pll and external sources arrive as
 * asynchronous levels much slower than clk_i and are synchronised.
 */
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "utp_params.svh"

// Functional notes
// - three independent 16-bit up-counting timers
// - timer clock is AND of two inputs
// - overflow sends pulse to interrupt logic
// - overflows strobe dac latch and adc start
// - count write loads preload, applies source
// - wrap at ffff raises interrupt
// - reload preload on wrap, keep counting
// - one passes other input, zero stops
// - selector codes 0000 to 0011 decoded
// - codes 0100 to 1111 pair slow sources
// - external source two accepted as clock source
// - rtc domain feeds slow clocks of all timers
// - pwm duty from 1 to 254 of 256
// - pwm period 256 cycles, width from port
// - timebase divides rtc into six ticks
// - ticks routed to lines 6 and 7
// - 2 hz rtc event wakes the cpu
module utp_timer #(
  parameter int TB_BITS = 14,
  parameter int PWM_W   = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        rtc_clk_i,
  input  wire logic        pll_clk_i,
  input  wire logic        external_source_one_i,
  input  wire logic        external_source_two_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [15:0] rdata_o,
  output logic             irq_o,
  output logic      [2:0]  ovf_pulse_o,
  output logic             dac_latch_o,
  output logic             adc_start_o,
  output logic      [1:0]  tb_normal_o,
  output logic      [1:0]  tb_fast_o,
  output logic             rtc_wake_o,
  output logic             pwm_output_o
);

  if (TB_BITS != 14) begin : g_chk_tb
    $error("timebase divider must be 14 bits");
  end
  if (PWM_W != 8) begin : g_chk_pwm
    $error("pwm counter must be 8 bits");
  end

  ////////////////////////////////////////////////////////////////////////

  // returns {constant one, AND level} for one selector code
  function automatic logic [1:0] src_decode(
    input logic [3:0] sel,
    input logic       rtc,
    input logic       pll,
    input logic       external_source_two,
    input logic [2:0] slow
  );
    logic in1;
    logic in2;
    in1 = 1'b0;
    in2 = 1'b0;
    case (sel[3:2])
      2'b00: begin
        case (sel[1:0])
          2'b00:   in1 = 1'b0;
          2'b01:   in1 = 1'b1;
          2'b10:   in1 = rtc;
          default: in1 = pll;
        endcase
        in2 = (sel[1:0] == 2'b00) ? 1'b0 :
              (sel[1:0] == 2'b01) ? 1'b1 : external_source_two;
      end
      default: begin
        in1 = (sel[3:2] == 2'b01) ? external_source_two :
              (sel[3:2] == 2'b10) ? rtc : pll;
        in2 = (sel[1:0] == 2'b11) ? 1'b1 : slow[sel[1:0]];
      end
    endcase
    src_decode = {sel == 4'h1, in1 & in2};
  endfunction

  function automatic logic pick(
    input utp_pkg::utp_strobe_t s,
    input logic [2:0]           ovf
  );
    case (s)
      utp_pkg::UTP_STB_A: pick = ovf[0];
      utp_pkg::UTP_STB_B: pick = ovf[1];
      utp_pkg::UTP_STB_C: pick = ovf[2];
      default:            pick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////

  utp_pkg::utp_state_t st_ff;
  utp_pkg::utp_state_t nxt_st;

  logic        rtc_rise;
  logic [5:0]  tick;
  logic [2:0]  slow;
  logic [2:0]  ovf;
  logic [8:0]  ev;
  logic [1:0]  dec;
  logic        step;
  logic [13:0] masks [6];

  assign masks[0] = `UTP_M_4K;
  assign masks[1] = `UTP_M_2K;
  assign masks[2] = `UTP_M_512;
  assign masks[3] = `UTP_M_64;
  assign masks[4] = `UTP_M_16;
  assign masks[5] = `UTP_M_2;

  always_comb begin
    nxt_st = st_ff;
    // pins pass two flops; only sync2 is looked at by logic
    nxt_st.sync1_ff = {external_source_two_i, external_source_one_i, pll_clk_i, rtc_clk_i};
    nxt_st.sync2_ff = st_ff.sync1_ff;

    // timebase divider on rtc rising edges
    rtc_rise = st_ff.sync2_ff[0] & ~st_ff.rtc_prev_ff;
    nxt_st.rtc_prev_ff = st_ff.sync2_ff[0];
    if (rtc_rise) begin
      nxt_st.tb_cnt_ff = st_ff.tb_cnt_ff + 14'h0001;
    end
    for (int i = 0; i < 6; i++) begin
      tick[i] = rtc_rise && ((st_ff.tb_cnt_ff & masks[i]) == masks[i]);
    end
    // slow square waves derived from the rtc divider
    slow = {st_ff.tb_cnt_ff[`UTP_TAP_2], st_ff.tb_cnt_ff[`UTP_TAP_16],
            st_ff.tb_cnt_ff[`UTP_TAP_64]};

    // timers
    ovf = 3'b000;
    dec = 2'b00;
    step = 1'b0;
    for (int t = 0; t < 3; t++) begin
      dec = src_decode(st_ff.sel_act_ff[t], st_ff.sync2_ff[0],
                       st_ff.sync2_ff[1], st_ff.sync2_ff[3], slow);
      nxt_st.lvl_prev_ff[t] = dec[0];
      // constant one has no edges, so it counts every clk_i
      step = dec[1] | (dec[0] & ~st_ff.lvl_prev_ff[t]);
      if (we_i && addr_i == 4'(3 * t + 1)) begin
        nxt_st.cnt_ff[t] = st_ff.pre_ff[t];
        nxt_st.sel_act_ff[t] = st_ff.sel_ff[t];
      end else if (step) begin
        if (st_ff.cnt_ff[t] == `UTP_CNT_MAX) begin
          nxt_st.cnt_ff[t] = st_ff.pre_ff[t];
          ovf[t] = 1'b1;
        end else begin
          nxt_st.cnt_ff[t] = st_ff.cnt_ff[t] + 16'h0001;
        end
      end
      if (we_i && addr_i == 4'(3 * t)) begin
        nxt_st.pre_ff[t] = wdata_i;
      end
      if (we_i && addr_i == 4'(3 * t + 2)) begin
        nxt_st.sel_ff[t] = wdata_i[3:0];
      end
    end
    nxt_st.ovf_ff = ovf;
    nxt_st.dac_ff = pick(st_ff.dac_sel_ff, ovf);
    nxt_st.adc_ff = pick(st_ff.adc_sel_ff, ovf);

    // timebase lines: 6 takes 4k/2k/512, 7 takes 64/16/2
    nxt_st.tbn_ff = {|tick[5:3] & ~st_ff.route_ff[1],
                     |tick[2:0] & ~st_ff.route_ff[0]};
    nxt_st.tbf_ff = {|tick[5:3] & st_ff.route_ff[1],
                     |tick[2:0] & st_ff.route_ff[0]};
    nxt_st.wake_ff = tick[5];

    // pwm free runs on clk_i
    nxt_st.pwm_cnt_ff = st_ff.pwm_cnt_ff + 8'h01;
    nxt_st.pwm_q_ff = (st_ff.pwm_w_ff >= `UTP_PWM_MIN) &&
                      (st_ff.pwm_w_ff <= `UTP_PWM_MAX) &&
                      (st_ff.pwm_cnt_ff < st_ff.pwm_w_ff);

    // sticky status: set wins over a clear in the same cycle
    ev = {tick, ovf};
    if (we_i && addr_i == `UTP_INT_CLEAR) begin
      nxt_st.stat_ff = st_ff.stat_ff & ~wdata_i[8:0];
    end
    nxt_st.stat_ff = nxt_st.stat_ff | ev;
    nxt_st.irq_ff = |(nxt_st.stat_ff & st_ff.en_ff);

    // writes to block-wide registers
    if (we_i) begin
      case (addr_i)
        `UTP_PWM_CTRL:   nxt_st.pwm_w_ff = wdata_i[7:0];
        `UTP_INT_ENABLE: nxt_st.en_ff = wdata_i[8:0];
        `UTP_ROUTE:      nxt_st.route_ff = wdata_i[1:0];
        `UTP_STROBE_SEL: begin
          nxt_st.dac_sel_ff = utp_pkg::utp_strobe_t'(wdata_i[1:0]);
          nxt_st.adc_sel_ff = utp_pkg::utp_strobe_t'(wdata_i[3:2]);
        end
        default: begin
        end
      endcase
    end

    // read data stands for one cycle only
    nxt_st.rdata_ff = `UTP_RST_WORD;
    if (re_i) begin
      case (addr_i)
        `UTP_A_PRELOAD:  nxt_st.rdata_ff = st_ff.pre_ff[0];
        `UTP_A_COUNT:    nxt_st.rdata_ff = st_ff.cnt_ff[0];
        `UTP_A_SELECT:   nxt_st.rdata_ff = {12'h000, st_ff.sel_ff[0]};
        `UTP_B_PRELOAD:  nxt_st.rdata_ff = st_ff.pre_ff[1];
        `UTP_B_COUNT:    nxt_st.rdata_ff = st_ff.cnt_ff[1];
        `UTP_B_SELECT:   nxt_st.rdata_ff = {12'h000, st_ff.sel_ff[1]};
        `UTP_C_PRELOAD:  nxt_st.rdata_ff = st_ff.pre_ff[2];
        `UTP_C_COUNT:    nxt_st.rdata_ff = st_ff.cnt_ff[2];
        `UTP_C_SELECT:   nxt_st.rdata_ff = {12'h000, st_ff.sel_ff[2]};
        `UTP_PWM_CTRL:   nxt_st.rdata_ff = {8'h00, st_ff.pwm_w_ff};
        `UTP_INT_STATUS: nxt_st.rdata_ff = {7'h00, st_ff.stat_ff};
        `UTP_INT_ENABLE: nxt_st.rdata_ff = {7'h00, st_ff.en_ff};
        `UTP_ROUTE:      nxt_st.rdata_ff = {14'h0000, st_ff.route_ff};
        `UTP_STROBE_SEL: nxt_st.rdata_ff = {12'h000, st_ff.adc_sel_ff,
                                            st_ff.dac_sel_ff};
        `UTP_PIN_LEVEL:  nxt_st.rdata_ff = {14'h0000, st_ff.sync2_ff[3:2]};
        default:         nxt_st.rdata_ff = `UTP_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o      = st_ff.rdata_ff;
  assign irq_o        = st_ff.irq_ff;
  assign ovf_pulse_o  = st_ff.ovf_ff;
  assign dac_latch_o  = st_ff.dac_ff;
  assign adc_start_o  = st_ff.adc_ff;
  assign tb_normal_o  = st_ff.tbn_ff;
  assign tb_fast_o    = st_ff.tbf_ff;
  assign rtc_wake_o   = st_ff.wake_ff;
  assign pwm_output_o = st_ff.pwm_q_ff;

  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // wrap on a counting step reloads and pulses
  a_wrap_reload: assert property (
    (st_ff.cnt_ff[0] == `UTP_CNT_MAX && !(we_i && addr_i == 4'h1) &&
     ovf[0]) |=> (st_ff.cnt_ff[0] == $past(st_ff.pre_ff[0]))
  ) else $error("timer a did not reload on wrap");

  a_wrap_pulse: assert property (
    ovf[0] |-> st_ff.cnt_ff[0] == `UTP_CNT_MAX
  ) else $error("timer a overflow without ffff");

  a_ovf_out: assert property (
    (ovf != 3'b000) |=> ovf_pulse_o == $past(ovf) &&
      (st_ff.stat_ff[2:0] & $past(ovf)) == $past(ovf)
  ) else $error("timer overflow not reported");

  a_count_load: assert property (
    (we_i && addr_i == `UTP_A_COUNT) |=>
      st_ff.cnt_ff[0] == $past(st_ff.pre_ff[0]) &&
      st_ff.sel_act_ff[0] == $past(st_ff.sel_ff[0])
  ) else $error("count write did not load preload");

  a_preload_keep: assert property (
    (we_i && addr_i == 4'h0 && !ovf[0] && st_ff.sel_act_ff[0] == 4'h0)
      |=> st_ff.cnt_ff[0] == $past(st_ff.cnt_ff[0])
  ) else $error("preload write changed the count");

  a_zero_stop: assert property (
    (st_ff.sel_act_ff[0] == 4'h0 && !we_i) |=> $stable(st_ff.cnt_ff[0])
  ) else $error("stopped timer counted");

  a_const_one: assert property (
    (st_ff.sel_act_ff[0] == 4'h1 && !we_i &&
     st_ff.cnt_ff[0] != `UTP_CNT_MAX)
      |=> st_ff.cnt_ff[0] == $past(st_ff.cnt_ff[0]) + 16'h0001
  ) else $error("constant one source did not count");

  a_pwm_range: assert property (
    (st_ff.pwm_w_ff == 8'h00 || st_ff.pwm_w_ff == 8'hFF) [*2]
      |-> !pwm_output_o
  ) else $error("pwm high outside duty range");

  a_pwm_width: assert property (
    (st_ff.pwm_cnt_ff == 8'h00 && st_ff.pwm_w_ff == 8'h03 && !we_i)
      ##1 !we_i ##1 !we_i
      |-> ($past(pwm_output_o) && pwm_output_o) ##1 pwm_output_o
          ##1 !pwm_output_o
  ) else $error("pwm pulse width wrong");

  a_dac_strobe: assert property (
    (st_ff.dac_sel_ff == utp_pkg::UTP_STB_A && ovf[0]) |=> dac_latch_o
  ) else $error("dac strobe missed overflow");

  a_wake_tick: assert property (
    rtc_wake_o |-> st_ff.stat_ff[8]
  ) else $error("wake without 2 hz status");

  a_set_wins: assert property (
    (ovf[0] && we_i && addr_i == `UTP_INT_CLEAR) |=> st_ff.stat_ff[0]
  ) else $error("clear swallowed an overflow");

  a_adc_strobe: assert property (
    (st_ff.adc_sel_ff == utp_pkg::UTP_STB_B && ovf[1]) |=> adc_start_o
  ) else $error("adc strobe missed overflow");

  a_line6_route: assert property (
    (|tick[2:0]) |=> tb_fast_o[0] == $past(st_ff.route_ff[0]) &&
      tb_normal_o[0] == !$past(st_ff.route_ff[0])
  ) else $error("line 6 tick misrouted");

  a_line7_route: assert property (
    (|tick[5:3]) |=> tb_fast_o[1] == $past(st_ff.route_ff[1]) &&
      tb_normal_o[1] == !$past(st_ff.route_ff[1])
  ) else $error("line 7 tick misrouted");

  a_tick_status: assert property (
    tick[0] |=> st_ff.stat_ff[`UTP_ST_TB]
  ) else $error("4 khz tick not in status");

  a_irq_level: assert property (
    (|(st_ff.stat_ff & st_ff.en_ff) &&
     !(we_i && addr_i == `UTP_INT_CLEAR))
      |=> irq_o
  ) else $error("enabled status without interrupt");

  a_sel_hold: assert property (
    (we_i && addr_i == `UTP_A_SELECT) |=> $stable(st_ff.sel_act_ff[0])
  ) else $error("select applied before count write");

  a_pwm_period: assert property (
    st_ff.pwm_cnt_ff == 8'hFF |=> st_ff.pwm_cnt_ff == 8'h00
  ) else $error("pwm period not 256 cycles");

  a_ext_edge: assert property (
    (st_ff.sel_act_ff[0] == 4'h7 && st_ff.sync2_ff[3] && !we_i &&
     !st_ff.lvl_prev_ff[0] && st_ff.cnt_ff[0] != `UTP_CNT_MAX)
      |=> st_ff.cnt_ff[0] == $past(st_ff.cnt_ff[0]) + 16'h0001
  ) else $error("external edge not counted");

  a_gate_low: assert property (
    (st_ff.sel_act_ff[0] == 4'h3 && !st_ff.sync2_ff[3] && !we_i)
      |=> $stable(st_ff.cnt_ff[0])
  ) else $error("gated timer counted");

  c_ovf_a: cover property (ovf_pulse_o[0]);
  c_pwm_on: cover property (pwm_output_o ##1 !pwm_output_o);
  c_tb_line6: cover property (tb_normal_o[0] || tb_fast_o[0]);
  c_irq: cover property (irq_o);
  c_adc_b: cover property (adc_start_o);

endmodule // utp_timer

// *** utp_src_model.sv ***
/*
 * model of the clock sources beside the timer block: the rtc
 * oscillator and the pll clock, both free running.
 * assumes the bench gives the timer block its own 10 MHz clock.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module utp_src_model #(
  parameter int RTC_HALF_NS = 800,
  parameter int PLL_HALF_NS = 730
) (
  output logic rtc_clk_o,
  output logic pll_clk_o
);
  // rtc runs far faster than 32768 hz so timebase ticks come in a short
  // run; it stays well below the block clock, so the sync still holds
  initial begin
    rtc_clk_o = 1'b0;
    pll_clk_o = 1'b0;
  end
  always #(RTC_HALF_NS) rtc_clk_o = ~rtc_clk_o;
  always #(PLL_HALF_NS) pll_clk_o = ~pll_clk_o;
endmodule // utp_src_model

// *** test_utp_timer.sv ***
/*
 * self-checking bench of the universal timer block over its register
 * port. assumes utp_params.svh, utp_pkg and utp_src_model are compiled.
 */
`timescale 1ns/1ps
`include "utp_params.svh"

////////////////////////////////////////////////////////////////////////
module test_utp_timer;
  logic        clk_i, rstn_i, external_source_one_i, external_source_two_i, we_i, re_i;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, d;
  logic        irq_o, dac_latch_o, adc_start_o, rtc_wake_o, pwm_output_o;
  logic [2:0]  ovf_pulse_o;
  logic [1:0]  tb_normal_o, tb_fast_o;
  logic        rtc_w, pll_w;
  int          err_total, checks, n, hi, dacs, adcs;
  logic [7:0]  pw [5]  = '{8'h00, 8'h01, 8'h03, 8'hFE, 8'hFF};
  int          pe [5]  = '{0, 1, 3, 254, 0};

  utp_src_model src (.rtc_clk_o(rtc_w), .pll_clk_o(pll_w));

  utp_timer dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .rtc_clk_i(rtc_w), .pll_clk_i(pll_w),
    .external_source_one_i(external_source_one_i), .external_source_two_i(external_source_two_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .ovf_pulse_o(ovf_pulse_o), .dac_latch_o(dac_latch_o),
    .adc_start_o(adc_start_o), .tb_normal_o(tb_normal_o),
    .tb_fast_o(tb_fast_o), .rtc_wake_o(rtc_wake_o),
    .pwm_output_o(pwm_output_o));

  always #50 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // bounded wait on one of the event outputs, returns cycles taken
  task automatic wait_sig(input int w, input int lim, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1 cnt++;
      s = (w == 0) ? ovf_pulse_o[0] : (w == 1) ? tb_normal_o[0] :
          (w == 2) ? tb_fast_o[0] : tb_normal_o[1];
    end while (s !== 1'b1 && cnt < lim);
    if (s !== 1'b1) begin
      err_total++;
      $display("ERROR event %0d did not arrive", w);
      give_verdict();
    end
  endtask

  task automatic external_source_two_pulses(input int k);
    repeat (k) begin
      @(posedge clk_i) external_source_two_i <= 1'b1;
      cyc(4);
      external_source_two_i <= 1'b0;
      cyc(4);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 0; rstn_i = 0; external_source_one_i = 0; external_source_two_i = 0; we_i = 0; re_i = 0;
    addr_i = '0; wdata_i = '0; err_total = 0; checks = 0;
    cyc(1);
    @(posedge clk_i) rstn_i <= 1'b1;
    #1 chk("irq at reset", {15'h0, irq_o}, 16'h0000);
    rd(`UTP_A_COUNT, d);  chk("count a reset", d, 16'h0000);
    rd(`UTP_INT_CLEAR, d); chk("clear reads zero", d, 16'h0000);
    // reload timer: preload fffe, every clock counts, two-cycle period
    wr(`UTP_STROBE_SEL, 16'h0009);
    wr(`UTP_A_PRELOAD, 16'hFFFE);
    wr(`UTP_A_SELECT, 16'h0001);
    wr(`UTP_A_COUNT, 16'h0000);
    // this clear lands on the first wrap, so the set must win
    wr(`UTP_INT_CLEAR, 16'h0001);
    wait_sig(0, 50, n);
    wait_sig(0, 50, n);
    chk("wrap interval", 16'(n), 16'h0002);
    dacs = 0;
    adcs = 0;
    repeat (20) begin
      @(posedge clk_i);
      #1 dacs += int'(dac_latch_o === 1'b1);
      adcs += int'(adc_start_o === 1'b1);
    end
    chk("dac strobes", 16'(dacs), 16'h000A);
    chk("adc strobes", 16'(adcs), 16'h0000);
    // timers b and c on constant one; adc strobe follows timer b
    wr(`UTP_B_PRELOAD, 16'hFFFE);
    wr(`UTP_B_SELECT, 16'h0001);
    wr(`UTP_B_COUNT, 16'h0000);
    wr(`UTP_C_PRELOAD, 16'hFFFE);
    wr(`UTP_C_SELECT, 16'h0001);
    wr(`UTP_C_COUNT, 16'h0000);
    adcs = 0;
    dacs = 0;
    hi = 0;
    repeat (20) begin
      @(posedge clk_i);
      #1 adcs += int'(adc_start_o === 1'b1);
      dacs += int'(ovf_pulse_o[1] === 1'b1);
      hi += int'(ovf_pulse_o[2] === 1'b1);
    end
    chk("adc strobes b", 16'(adcs), 16'h000A);
    chk("timer b wraps", 16'(dacs), 16'h000A);
    chk("timer c wraps", 16'(hi), 16'h000A);
    rd(`UTP_INT_STATUS, d); chk("status a", d & 16'h0001, 16'h0001);
    #1 chk("irq masked", {15'h0, irq_o}, 16'h0000);
    wr(`UTP_INT_ENABLE, 16'h0001);
    cyc(1);
    #1 chk("irq raised", {15'h0, irq_o}, 16'h0001);
    // stop with code 0000, then clear the sticky bit
    wr(`UTP_A_SELECT, 16'h0000);
    wr(`UTP_A_COUNT, 16'h0000);
    cyc(4);
    wr(`UTP_INT_CLEAR, 16'h0001);
    rd(`UTP_INT_STATUS, d); chk("status cleared", d & 16'h0001, 16'h0000);
    #1 chk("irq cleared", {15'h0, irq_o}, 16'h0000);
    rd(`UTP_A_COUNT, d);  chk("stopped count", d, 16'hFFFE);
    wr(`UTP_A_PRELOAD, 16'h1234);
    cyc(10);
    rd(`UTP_A_COUNT, d);  chk("preload only", d, 16'hFFFE);
    wr(`UTP_A_COUNT, 16'hBEEF);
    rd(`UTP_A_COUNT, d);  chk("count reload", d, 16'h1234);
    // code 0111: external source two gated by constant one
    wr(`UTP_A_PRELOAD, 16'h0010);
    wr(`UTP_A_SELECT, 16'h0007);
    wr(`UTP_A_COUNT, 16'h0000);
    external_source_two_pulses(5);
    rd(`UTP_A_COUNT, d);  chk("external_source_two edges", d, 16'h0015);
    // code 0011 with source two held low never counts
    wr(`UTP_A_SELECT, 16'h0003);
    wr(`UTP_A_COUNT, 16'h0000);
    cyc(60);
    rd(`UTP_A_COUNT, d);  chk("pll gated", d, 16'h0010);
    @(posedge clk_i) begin
      external_source_one_i <= 1'b1;
      external_source_two_i <= 1'b1;
    end
    cyc(4);
    rd(`UTP_PIN_LEVEL, d); chk("pin levels", d, 16'h0003);
    // timebase 4 khz tick on line 6, normal then fast routing
    wr(`UTP_INT_ENABLE, 16'h0008);
    wait_sig(1, 400, n);
    wr(`UTP_ROUTE, 16'h0001);
    wait_sig(2, 400, n);
    wait_sig(3, 9000, n);
    rd(`UTP_INT_STATUS, d); chk("tick status", d & 16'h0008, 16'h0008);
    chk("line 7 status", d & 16'h0040, 16'h0040);
    #1 chk("tick irq", {15'h0, irq_o}, 16'h0001);
    wr(`UTP_INT_ENABLE, 16'h0000);
    // pwm high time over one 256-cycle period, inside and outside range
    for (int i = 0; i < 5; i++) begin
      wr(`UTP_PWM_CTRL, {8'h00, pw[i]});
      cyc(300);
      hi = 0;
      repeat (256) begin
        @(posedge clk_i);
        #1 hi += int'(pwm_output_o === 1'b1);
      end
      chk("pwm width", 16'(hi), 16'(pe[i]));
    end
    give_verdict();
  end

  initial begin
    #9_000_000;
    err_total++;
    $display("ERROR run time limit reached");
    give_verdict();
  end
endmodule // test_utp_timer
